//--- logic/mpc_pkg.sv
// Purpose: constants shared by the protection control register block
// Assumes: APB with 32-bit data, two register words
// Notes: offsets are byte addresses, the control reset value is a three-bit field
package mpc_pkg;
   localparam logic [11:0] MPC_CTRL_OFS = 12'h000;
   localparam logic [11:0] MPC_STAT_OFS = 12'h004;
   localparam int MPC_ENABLE_BIT = 0;
   localparam int MPC_HANDLER_BIT = 1;
   localparam int MPC_BGMAP_BIT = 2;
   localparam logic [2:0] MPC_CTRL_RESET = 3'h0;
   localparam logic [31:0] MPC_UNMAPPED_DATA = 32'h0000_0000;
   typedef enum logic [2:0] {
      MPC_CHK_OFF = 3'b001,
      MPC_CHK_ON = 3'b010,
      MPC_CHK_SUSPENDED = 3'b100
   } mpc_mode_t;
endpackage

//--- logic/mpc_apb_slave.sv
// Purpose: apb slave holding the protection control word
// Assumes: zero wait states, pready always high
// Notes: unmapped addresses read zero and answer pslverr
`timescale 1ns/1ps
`default_nettype none
module mpc_apb_slave
   import mpc_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // block side
   input wire logic [31:0] status_word,
   output logic [2:0] ctrl_q
);
   logic access;
   logic [31:0] prdata_q;
   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access && (paddr != MPC_CTRL_OFS) && (paddr != MPC_STAT_OFS);
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= MPC_CTRL_RESET;
      end else if (access && pwrite && paddr == MPC_CTRL_OFS) begin
         ctrl_q <= pwdata[2:0];
      end
   end

   // read data prepared in setup so it stands during the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= MPC_UNMAPPED_DATA;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == MPC_CTRL_OFS) begin
            prdata_q <= {29'h0, ctrl_q};
         end else if (paddr == MPC_STAT_OFS) begin
            prdata_q <= status_word;
         end else begin
            prdata_q <= MPC_UNMAPPED_DATA;
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/mpc_region_match.sv
// Purpose: finds whether an address hits any enabled region
// Assumes: regions given as inclusive base and limit pairs
// Notes: lowest numbered hit wins when regions overlap
`timescale 1ns/1ps
`default_nettype none
module mpc_region_match
   import mpc_pkg::*;
#(
   parameter int NUM_REGIONS = 8
) (
   // query
   input wire logic [31:0] addr,
   input wire logic [NUM_REGIONS-1:0] region_en,
   input wire logic [NUM_REGIONS*32-1:0] region_base,
   input wire logic [NUM_REGIONS*32-1:0] region_limit,
   input wire logic [NUM_REGIONS*4-1:0] region_perm,
   // result
   output logic hit,
   output logic [3:0] perm
);
   // the region index space of the checker stops at sixteen
   if (NUM_REGIONS < 1 || NUM_REGIONS > 16) begin : g_bad_regions
      $error("NUM_REGIONS out of range");
   end
   logic [NUM_REGIONS-1:0] hits;
   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g++) begin : g_reg
         assign hits[g] = region_en[g] && addr >= region_base[g*32 +: 32]
            && addr <= region_limit[g*32 +: 32];
      end
   endgenerate
   always_comb begin
      hit = |hits;
      perm = 4'h0;
      for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
         if (hits[i]) begin
            perm = region_perm[i*4 +: 4];
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/mpc_ctrl.sv
// Purpose: protection control register and access checker
// Assumes: one access request per cycle, answer registered
// Notes: perm bits are {exec, write, read, unpriv}
// Function
// - no background map: unmatched access faults
// - background map serves privileged accesses only
// - enabled regions override background map
// - handler bit clear suspends checks in handlers
`timescale 1ns/1ps
`default_nettype none
module mpc_ctrl
   import mpc_pkg::*;
#(
   parameter int NUM_REGIONS = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // region table from the region registers
   input wire logic [NUM_REGIONS-1:0] region_en,
   input wire logic [NUM_REGIONS*32-1:0] region_base,
   input wire logic [NUM_REGIONS*32-1:0] region_limit,
   input wire logic [NUM_REGIONS*4-1:0] region_perm,
   // access request from the core
   input wire logic acc_valid,
   input wire logic [31:0] acc_addr,
   input wire logic acc_priv,
   input wire logic acc_write,
   input wire logic acc_exec,
   input wire logic in_fault_handler,
   // answer
   output logic acc_done,
   output logic acc_fault,
   output logic [3:0] acc_perm,
   // control bits to the memory path
   output logic prot_enable,
   output logic background_map_enable,
   output logic handler_protection_enable
);
   logic [2:0] ctrl_q;
   logic [31:0] status_word;
   logic hit;
   logic [3:0] hit_perm;
   mpc_mode_t mode;
   logic fault_d;
   logic [3:0] perm_d;
   logic done_q;
   logic fault_q;
   logic [3:0] perm_q;
   logic fault_seen_q;

   // the region matcher serves one to sixteen regions only
   if (NUM_REGIONS < 1 || NUM_REGIONS > 16) begin : g_bad_regions
      $error("NUM_REGIONS out of range");
   end

   mpc_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .status_word(status_word),
      .ctrl_q(ctrl_q)
   );

   mpc_region_match #(.NUM_REGIONS(NUM_REGIONS)) u_match (
      .addr(acc_addr),
      .region_en(region_en),
      .region_base(region_base),
      .region_limit(region_limit),
      .region_perm(region_perm),
      .hit(hit),
      .perm(hit_perm)
   );

   assign prot_enable = ctrl_q[MPC_ENABLE_BIT];
   assign background_map_enable = ctrl_q[MPC_BGMAP_BIT];
   assign handler_protection_enable = ctrl_q[MPC_HANDLER_BIT];

   // handler bit with enable clear is undefined; we simply stay off
   always_comb begin
      if (!prot_enable) begin
         mode = MPC_CHK_OFF;
      end else if (in_fault_handler && !handler_protection_enable) begin
         mode = MPC_CHK_SUSPENDED;
      end else begin
         mode = MPC_CHK_ON;
      end
   end

   always_comb begin
      fault_d = 1'b0;
      perm_d = 4'hF;
      case (mode)
         MPC_CHK_ON: begin
            if (hit) begin
               perm_d = hit_perm;
               fault_d = (!hit_perm[1]) || (acc_write && !hit_perm[2])
                  || (acc_exec && !hit_perm[3]) || (!acc_priv && !hit_perm[0]);
            end else if (background_map_enable && acc_priv) begin
               perm_d = 4'hE;
            end else begin
               perm_d = 4'h0;
               fault_d = 1'b1;
            end
         end
         default: begin
            perm_d = 4'hF;
            fault_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         fault_q <= 1'b0;
         perm_q <= 4'h0;
      end else begin
         done_q <= acc_valid;
         fault_q <= acc_valid && fault_d;
         perm_q <= acc_valid ? perm_d : 4'h0;
      end
   end

   // sticky record of faults, cleared when protection is switched off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_seen_q <= 1'b0;
      end else if (acc_valid && fault_d) begin
         fault_seen_q <= 1'b1;
      end else if (!prot_enable) begin
         fault_seen_q <= 1'b0;
      end
   end

   assign status_word = {27'h0, fault_seen_q, mode == MPC_CHK_SUSPENDED,
      mode == MPC_CHK_ON, fault_q, done_q};
   assign acc_done = done_q;
   assign acc_fault = fault_q;
   assign acc_perm = perm_q;

   // assertions
   // with protection enabled, checking is live unless a handler runs with the handler bit clear
   nobg_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_q[0] && !ctrl_q[2] && (ctrl_q[1] || !in_fault_handler) && !hit
      |=> acc_fault)
      else $error("unmatched access did not fault");
   handler_chk_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_q == 3'b011 && in_fault_handler && !hit |=> acc_fault)
      else $error("handler access escaped checking");
   bg_priv_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_q[0] && ctrl_q[2] && !hit && !in_fault_handler
      |=> acc_fault == !$past(acc_priv))
      else $error("background map privilege handling wrong");
   bg_perm_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_q[0] && ctrl_q[2] && !hit && acc_priv
      && (ctrl_q[1] || !in_fault_handler) |=> acc_perm == 4'hE && !acc_fault)
      else $error("privileged background access not granted");
   region_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && prot_enable && hit && mode == MPC_CHK_ON
      |=> acc_perm == $past(hit_perm))
      else $error("region did not override background");
   handler_susp_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && prot_enable && !ctrl_q[1] && in_fault_handler |=> !acc_fault)
      else $error("fault raised in suspended handler");
   off_nofault_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid && !prot_enable |=> !acc_fault)
      else $error("fault raised while disabled");
   ctrl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && paddr == MPC_CTRL_OFS |-> prdata[31:3] == 29'h0)
      else $error("reserved control bits read nonzero");
   ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && paddr == MPC_CTRL_OFS
      |=> ctrl_q == $past(pwdata[2:0]))
      else $error("control write not taken");
   done_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_valid |=> acc_done ##1 (acc_done == $past(acc_valid)))
      else $error("answer timing wrong");
   // fault and sticky record are set on the same edge
   sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_fault |-> fault_seen_q)
      else $error("fault not recorded");

   fault_c: cover property (@(posedge pclk) disable iff (!presetn) acc_fault);
   bg_c: cover property (@(posedge pclk) disable iff (!presetn)
      acc_valid && prot_enable && background_map_enable && !hit && acc_priv);
   susp_c: cover property (@(posedge pclk) disable iff (!presetn)
      acc_valid && mode == MPC_CHK_SUSPENDED);
   handler_c: cover property (@(posedge pclk) disable iff (!presetn)
      acc_valid && prot_enable && handler_protection_enable && in_fault_handler);
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the protection control block
// Assumes: apb slave answers with pready, access answer one cycle later
// Notes: two overlapping regions, the rest disabled
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd;
   logic [7:0] region_en;
   logic [255:0] region_base, region_limit;
   logic [31:0] region_perm, acc_addr;
   logic acc_valid, acc_priv, acc_write, acc_exec, in_fault_handler;
   logic acc_done, acc_fault, prot_enable, background_map_enable, handler_protection_enable;
   logic [3:0] acc_perm;
   logic [31:0] addrs [3] = '{32'h0000_1800, 32'h0000_2800, 32'h0000_5000};
   logic [31:0] cv;
   logic sticky;
   int n_fail, comparisons;

   mpc_ctrl #(.NUM_REGIONS(8)) u_mpc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .region_en(region_en), .region_base(region_base),
      .region_limit(region_limit), .region_perm(region_perm), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_priv(acc_priv), .acc_write(acc_write), .acc_exec(acc_exec),
      .in_fault_handler(in_fault_handler), .acc_done(acc_done), .acc_fault(acc_fault),
      .acc_perm(acc_perm), .prot_enable(prot_enable),
      .background_map_enable(background_map_enable),
      .handler_protection_enable(handler_protection_enable));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // region 0 wins the overlap: read and unprivileged only
   function automatic logic exp_fault(input logic [31:0] a, input logic p, w, x, h,
                                      input logic [2:0] c);
      logic [3:0] pm;
      if (!c[0] || (h && !c[1])) return 1'b0;
      if (a >= 32'h0000_1000 && a <= 32'h0000_1fff) pm = 4'b0011;
      else if (a >= 32'h0000_1800 && a <= 32'h0000_2fff) pm = 4'b1111;
      else return !(c[2] && p);
      return !pm[1] || (w && !pm[2]) || (x && !pm[3]) || (!p && !pm[0]);
   endfunction

   // permission word reported; full access while not checking
   function automatic logic [3:0] exp_perm(input logic [31:0] a, input logic p, h,
                                           input logic [2:0] c);
      if (!c[0] || (h && !c[1])) return 4'hf;
      if (a >= 32'h0000_1000 && a <= 32'h0000_1fff) return 4'h3;
      if (a >= 32'h0000_1800 && a <= 32'h0000_2fff) return 4'hf;
      return (c[2] && p) ? 4'he : 4'h0;
   endfunction

   // software never sets the handler bit with protection off
   function automatic logic [31:0] r5_legal(input logic [31:0] d);
      return d[1] ? (d | 32'h0000_0001) : d;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         chk("pready_timeout", pready, 1'b1);
         close_out();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic set_ctrl(input logic [31:0] d);
      apb(1'b1, MPC_CTRL_OFS, d);
      #1;
      chk("enable", prot_enable, d[0]);
      chk("bgmap", background_map_enable, d[2]);
      chk("handler", handler_protection_enable, d[1]);
      apb(1'b0, MPC_CTRL_OFS, 32'h0000_0000);
      chk("ctrl_read", rd, {29'h0, d[2:0]});
      chk("ctrl_err", err, 1'b0);
      if (!d[0]) sticky = 1'b0;
   endtask

   // status: sticky fault, suspended, checking on; done and fault idle by now
   task automatic chk_status(input logic [2:0] c);
      logic susp;
      susp = c[0] && in_fault_handler && !c[1];
      apb(1'b0, MPC_STAT_OFS, 32'h0000_0000);
      chk("status", rd, {27'h0, sticky, susp, c[0] && !susp, 2'b00});
   endtask

   task automatic acc(input logic [31:0] a, input logic p, w, x, h, input logic [2:0] c);
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_priv <= p;
      acc_write <= w;
      acc_exec <= x;
      in_fault_handler <= h;
      @(posedge pclk);
      acc_valid <= 1'b0;
      #1;
      chk("acc_done", acc_done, 1'b1);
      chk("acc_fault", acc_fault, exp_fault(a, p, w, x, h, c));
      chk("acc_perm", acc_perm, exp_perm(a, p, h, c));
      if (exp_fault(a, p, w, x, h, c)) sticky = 1'b1;
   endtask

   initial begin
      {presetn, psel, penable, pwrite, acc_valid, acc_priv, acc_write, acc_exec} = '0;
      in_fault_handler = 1'b0;
      paddr = '0;
      pwdata = '0;
      acc_addr = '0;
      n_fail = 0;
      comparisons = 0;
      sticky = 1'b0;
      rnd = 32'h2099_863b;
      region_en = 8'h03;
      region_base = {192'h0, 32'h0000_1800, 32'h0000_1000};
      region_limit = {192'h0, 32'h0000_2fff, 32'h0000_1fff};
      region_perm = 32'h0000_00f3;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, MPC_CTRL_OFS, 32'h0000_0000);
      chk("reset_ctrl", rd, {29'h0, MPC_CTRL_RESET});
      // unmapped word: error, write dropped, zero read
      apb(1'b1, 12'h008, 32'hffff_ffff);
      chk("unmapped_werr", err, 1'b1);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("unmapped_rerr", err, 1'b1);
      chk("unmapped_data", rd, MPC_UNMAPPED_DATA);
      set_ctrl(32'hffff_fff8);
      set_ctrl(32'hffff_ffff);
      $display("register tests done");
      // every legal control code against a matrix of access kinds
      for (int c = 0; c < 8; c++) begin
         cv = r5_legal(c);
         set_ctrl(cv);
         for (int k = 0; k < 48; k++) begin
            acc(addrs[k%3], k[2], k[3], k[4], k[5], cv[2:0]);
         end
         chk_status(cv[2:0]);
      end
      $display("directed access tests done");
      for (int n = 0; n < 100; n++) begin
         rnd = xs(rnd);
         cv = r5_legal(rnd);
         set_ctrl(cv);
         for (int k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            acc({18'h0, rnd[13:0]}, rnd[14], rnd[15], rnd[16], rnd[17], cv[2:0]);
         end
         chk_status(cv[2:0]);
      end
      $display("random tests done");
      close_out();
   end
endmodule
`default_nettype wire
